// >>> include/tasr_map.vh
`ifndef TASR_MAP_VH
`define TASR_MAP_VH
// Field positions of the authentication status word.
`define TASR_ROOT_NI_HI      27
`define TASR_ROOT_NI_LO      26
`define TASR_ROOT_I_HI       25
`define TASR_ROOT_I_LO       24
`define TASR_REALM_NI_HI     15
`define TASR_REALM_NI_LO     14
`define TASR_REALM_I_HI      13
`define TASR_REALM_I_LO      12
`define TASR_HYP_NI_HI       11
`define TASR_HYP_NI_LO       10
`define TASR_HYP_I_HI        9
`define TASR_HYP_I_LO        8
`define TASR_SEC_NI_HI       7
`define TASR_SEC_NI_LO       6
`define TASR_SEC_I_HI        5
`define TASR_SEC_I_LO        4
`define TASR_NS_NI_HI        3
`define TASR_NS_NI_LO        2
`define TASR_NS_I_HI         1
`define TASR_NS_I_LO         0
// Two-bit debug field codes.
`define TASR_DBG_ABSENT      2'h0
`define TASR_DBG_DISABLED    2'h2
`define TASR_DBG_ENABLED     2'h3
// Reset value of the word and of the ext view.
`define TASR_RESET_WORD      64'h0000000000000000
// Exception levels and access outcomes.
`define TASR_EL0             2'h0
`define TASR_EL1             2'h1
`define TASR_EL2             2'h2
`define TASR_EL3             2'h3
`define TASR_RES_OK          2'h0
`define TASR_RES_UNDEF       2'h1
`define TASR_RES_TRAP        2'h2
// Syndrome class reported for a trapped system access.
`define TASR_TRAP_CLASS      6'h18
`endif

// >>> verilog/tasr_write_check.v
`include "tasr_map.vh"

// Decides the outcome of a write to the trace buffer status register.
module tasr_write_check (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       reset_n_i,
  // Request
  input  wire       req_i,
  input  wire [1:0] el_i,
  input  wire       trap_el2_i,
  input  wire       trap_el3_i,
  // Outcome
  output reg        done_o,
  output reg  [1:0] result_o,
  output reg  [1:0] trap_el_o
);

  reg [1:0] next_result;
  reg [1:0] next_trap_el;

  always @* begin
    next_result  = `TASR_RES_OK;
    next_trap_el = `TASR_EL0;
    case (el_i)
      `TASR_EL0: begin
        next_result = `TASR_RES_UNDEF;
      end
      `TASR_EL1: begin
        if (trap_el2_i) begin
          next_result  = `TASR_RES_TRAP;
          next_trap_el = `TASR_EL2;
        end else if (trap_el3_i) begin
          next_result  = `TASR_RES_TRAP;
          next_trap_el = `TASR_EL3;
        end
      end
      `TASR_EL2: begin
        if (trap_el3_i) begin
          next_result  = `TASR_RES_TRAP;
          next_trap_el = `TASR_EL3;
        end
      end
      default: begin
        next_result = `TASR_RES_OK;
      end
    endcase
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_o    <= 1'b0;
      result_o  <= `TASR_RES_OK;
      trap_el_o <= `TASR_EL0;
    end else begin
      done_o <= req_i;
      if (req_i) begin
        result_o  <= next_result;
        trap_el_o <= next_trap_el;
      end
    end
  end

endmodule // tasr_write_check

// >>> verilog/tasr_regs.v
`include "tasr_map.vh"

module tasr_regs #(
  parameter TRACE_PRESENT = 1
) (
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        reset_n_i,
  // Authentication inputs
  input  wire [1:0]  main_root_ni_i,
  input  wire [1:0]  main_realm_ni_i,
  input  wire [1:0]  secure_ni_i,
  input  wire [1:0]  nonsecure_ni_i,
  // System read of the status word
  input  wire        sys_rd_i,
  input  wire [1:0]  sys_el_i,
  output reg         sys_rd_done_o,
  output reg         sys_rd_undef_o,
  output reg  [63:0] sys_rd_data_o,
  // External debugger read
  input  wire        ext_rd_i,
  output reg         ext_rd_done_o,
  output reg  [31:0] ext_rd_data_o,
  // Trace buffer status write check
  input  wire        tbs_wr_i,
  input  wire [1:0]  tbs_el_i,
  input  wire        tbs_trap_el2_i,
  input  wire        tbs_trap_el3_i,
  output reg         tbs_wr_done_o,
  output reg  [1:0]  tbs_wr_result_o,
  output reg  [1:0]  tbs_wr_trap_el_o,
  output reg  [5:0]  tbs_wr_class_o
);

  // Field codes of the status word, one wire per two-bit field.
  wire [1:0]  root_ni_field;
  wire [1:0]  root_i_field;
  wire [1:0]  realm_ni_field;
  wire [1:0]  realm_i_field;
  wire [1:0]  hyp_ni_field;
  wire [1:0]  hyp_i_field;
  wire [1:0]  sec_ni_field;
  wire [1:0]  sec_i_field;
  wire [1:0]  ns_ni_field;
  wire [1:0]  ns_i_field;
  wire        trace_present;

  // Next values of the read and write answers.
  reg  [63:0] next_word;
  reg         next_sys_undef;
  reg  [63:0] next_sys_data;
  reg  [31:0] next_ext_data;
  reg  [5:0]  next_class;

  // Outcome of the write check, one cycle after the request.
  wire        chk_done;
  wire [1:0]  chk_result;
  wire [1:0]  chk_trap_el;

  // The trace feature is fixed at build time, so a parameter stands in for it.
  assign trace_present = (TRACE_PRESENT != 0);

  // Root and realm non-invasive codes are copied, never re-decoded, so the
  // two status registers cannot disagree about them.
  assign root_ni_field  = main_root_ni_i;
  assign root_i_field   = `TASR_DBG_ABSENT;
  assign realm_ni_field = main_realm_ni_i;
  assign realm_i_field  = `TASR_DBG_ABSENT;

  // There is no separate hypervisor enable, so both hyp fields read absent.
  assign hyp_ni_field   = `TASR_DBG_ABSENT;
  assign hyp_i_field    = `TASR_DBG_ABSENT;

  // Secure and non-secure levels come in ready coded; invasive debug is absent.
  assign sec_ni_field   = secure_ni_i;
  assign sec_i_field    = `TASR_DBG_ABSENT;
  assign ns_ni_field    = nonsecure_ni_i;
  assign ns_i_field     = `TASR_DBG_ABSENT;

  // One combinational word feeds both views, so they agree when both are read in the same cycle and the system read is not refused.
  always @* begin
    next_word = `TASR_RESET_WORD;
    next_word[`TASR_ROOT_NI_HI:`TASR_ROOT_NI_LO]   = root_ni_field;
    next_word[`TASR_ROOT_I_HI:`TASR_ROOT_I_LO]     = root_i_field;
    next_word[`TASR_REALM_NI_HI:`TASR_REALM_NI_LO] = realm_ni_field;
    next_word[`TASR_REALM_I_HI:`TASR_REALM_I_LO]   = realm_i_field;
    next_word[`TASR_HYP_NI_HI:`TASR_HYP_NI_LO]     = hyp_ni_field;
    next_word[`TASR_HYP_I_HI:`TASR_HYP_I_LO]       = hyp_i_field;
    next_word[`TASR_SEC_NI_HI:`TASR_SEC_NI_LO]     = sec_ni_field;
    next_word[`TASR_SEC_I_HI:`TASR_SEC_I_LO]       = sec_i_field;
    next_word[`TASR_NS_NI_HI:`TASR_NS_NI_LO]       = ns_ni_field;
    next_word[`TASR_NS_I_HI:`TASR_NS_I_LO]         = ns_i_field;
  end

  // A read at the lowest level, or with no trace feature, is undefined and
  // returns zero rather than the word, so nothing leaks to a refused caller.
  // The level check comes second: with no trace feature every level is refused.
  always @* begin
    next_sys_undef = 1'h0;
    next_sys_data  = `TASR_RESET_WORD;
    if (!trace_present) begin
      next_sys_undef = 1'h1;
    end else if (sys_el_i == `TASR_EL0) begin
      next_sys_undef = 1'h1;
    end else begin
      next_sys_data = next_word;
    end
  end

  // The external view has no level check: the debugger reaches it directly.
  // It also answers with no trace feature; gating that is left to the debug port.
  always @* begin
    next_ext_data = next_word[31:0];
  end

  // Done is a one-cycle pulse that marks the answer of every system read.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_rd_done_o <= 1'h0;
    end else begin
      sys_rd_done_o <= sys_rd_i;
    end
  end

  // Undefined is a pulse beside done, never a held flag.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_rd_undef_o <= 1'h0;
    end else begin
      sys_rd_undef_o <= sys_rd_i & next_sys_undef;
    end
  end

  // The read data holds until the next read so a slow consumer may take it late.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_rd_data_o <= `TASR_RESET_WORD;
    end else if (sys_rd_i) begin
      sys_rd_data_o <= next_sys_data;
    end
  end

  // The debugger gets its own done pulse, independent of any system read.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_rd_done_o <= 1'h0;
    end else begin
      ext_rd_done_o <= ext_rd_i;
    end
  end

  // The low word holds between debugger reads, like the system read data.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_rd_data_o <= 32'h00000000;
    end else if (ext_rd_i) begin
      ext_rd_data_o <= next_ext_data;
    end
  end

  // The privilege and trap decode of a write lives in its own module so that
  // its priority order can be changed without touching the read paths.
  tasr_write_check u_write_check (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .req_i      (tbs_wr_i),
    .el_i       (tbs_el_i),
    .trap_el2_i (tbs_trap_el2_i),
    .trap_el3_i (tbs_trap_el3_i),
    .done_o     (chk_done),
    .result_o   (chk_result),
    .trap_el_o  (chk_trap_el)
  );

  // The syndrome class is only meaningful for a trap; other outcomes report zero.
  always @* begin
    if (chk_result == `TASR_RES_TRAP) begin
      next_class = `TASR_TRAP_CLASS;
    end else begin
      next_class = 6'h00;
    end
  end

  // Re-registered so every top output comes straight from a flip-flop; this
  // costs one cycle, which is why the write answer lags the read answers.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbs_wr_done_o <= 1'h0;
    end else begin
      tbs_wr_done_o <= chk_done;
    end
  end

  // The outcome holds after done falls, until the next request's answer.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbs_wr_result_o <= `TASR_RES_OK;
    end else begin
      tbs_wr_result_o <= chk_result;
    end
  end

  // The trap target is zero unless the outcome is a trap.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbs_wr_trap_el_o <= `TASR_EL0;
    end else begin
      tbs_wr_trap_el_o <= chk_trap_el;
    end
  end

  // The class follows the outcome in the same cycle, so the two never disagree.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbs_wr_class_o <= 6'h00;
    end else begin
      tbs_wr_class_o <= next_class;
    end
  end

endmodule // tasr_regs

// >>> tb/tasr_auth_src.sv
// Authentication levels that the debug domain presents to the block.
module tasr_auth_src (
  input  wire logic [1:0] sel_i,
  output logic      [1:0] root_o,
  output logic      [1:0] realm_o,
  output logic      [1:0] sec_o,
  output logic      [1:0] ns_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // The four fields differ per selector so that a swapped field shows up.
  assign root_o  = sel_i;
  assign realm_o = ~sel_i;
  assign sec_o   = sel_i ^ 2'h1;
  assign ns_o    = sel_i ^ 2'h2;
endmodule // tasr_auth_src

// >>> tb/tasr_regs_assertions.sv
module tasr_regs_checker #(
  parameter TRACE_PRESENT = 1
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Authentication inputs
  input  wire logic [1:0]  main_root_ni_i,
  input  wire logic [1:0]  main_realm_ni_i,
  // System read
  input  wire logic        sys_rd_i,
  input  wire logic [1:0]  sys_el_i,
  input  wire logic        sys_rd_done_o,
  input  wire logic        sys_rd_undef_o,
  input  wire logic [63:0] sys_rd_data_o,
  // External read
  input  wire logic        ext_rd_i,
  input  wire logic        ext_rd_done_o,
  input  wire logic [31:0] ext_rd_data_o,
  // Trace buffer status write check
  input  wire logic        tbs_wr_i,
  input  wire logic [1:0]  tbs_el_i,
  input  wire logic        tbs_trap_el2_i,
  input  wire logic        tbs_trap_el3_i,
  input  wire logic        tbs_wr_done_o,
  input  wire logic [1:0]  tbs_wr_result_o,
  input  wire logic [1:0]  tbs_wr_trap_el_o,
  input  wire logic [5:0]  tbs_wr_class_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_sys_rd_latency: assert property (sys_rd_i |=> sys_rd_done_o)
    else $error("read done late");
  a_reserved_zero: assert property (sys_rd_done_o |->
    sys_rd_data_o[63:28] == 0 && sys_rd_data_o[23:16] == 0) else $error("reserved set");
  a_undef_read: assert property (sys_rd_i && (sys_el_i == 0 || !TRACE_PRESENT)
    |=> sys_rd_undef_o && sys_rd_data_o == 0) else $error("undef read missed");
  a_root_realm_copy: assert property (
    sys_rd_i && sys_el_i != 0 && TRACE_PRESENT != 0 |=>
    sys_rd_data_o[27:26] == $past(main_root_ni_i)
    && sys_rd_data_o[15:14] == $past(main_realm_ni_i)) else $error("copy wrong");
  a_hyp_ni_zero: assert property (sys_rd_done_o |-> sys_rd_data_o[11:10] == 0)
    else $error("hyp ni set");
  a_hyp_inv_zero: assert property (sys_rd_done_o |-> sys_rd_data_o[9:8] == 0)
    else $error("hyp inv set");
  a_ext_low_match: assert property (
    ext_rd_i && sys_rd_i && sys_el_i != 0 && TRACE_PRESENT != 0 |=>
    ext_rd_done_o && ext_rd_data_o == sys_rd_data_o[31:0]) else $error("views differ");
  a_ext_rd_latency: assert property (ext_rd_i |=> ext_rd_done_o)
    else $error("ext read done late");
  a_wr_el2_trap: assert property (
    tbs_wr_i && tbs_el_i == 1 && tbs_trap_el2_i |-> ##2 tbs_wr_done_o
    && tbs_wr_result_o == 2'h2 && tbs_wr_trap_el_o == 2'h2) else $error("el2 trap missed");
  a_wr_el3_ok: assert property (
    tbs_wr_i && tbs_el_i == 3 |-> ##2 tbs_wr_done_o
    && tbs_wr_result_o == 2'h0 && tbs_wr_class_o == 6'h0) else $error("el3 write refused");
  a_wr_el0_undef: assert property (tbs_wr_i && tbs_el_i == 0 |->
    ##2 tbs_wr_done_o && tbs_wr_result_o == 2'h1) else $error("el0 write");
  a_wr_class: assert property (tbs_wr_done_o |->
    tbs_wr_class_o == (tbs_wr_result_o == 2'h2 ? 6'h18 : 6'h0)) else $error("class");
endmodule // tasr_regs_checker
bind tasr_regs tasr_regs_checker #(.TRACE_PRESENT(TRACE_PRESENT)) u_chk (
  .core_clk_i       (core_clk_i),
  .reset_n_i        (reset_n_i),
  .main_root_ni_i   (main_root_ni_i),
  .main_realm_ni_i  (main_realm_ni_i),
  .sys_rd_i         (sys_rd_i),
  .sys_el_i         (sys_el_i),
  .sys_rd_done_o    (sys_rd_done_o),
  .sys_rd_undef_o   (sys_rd_undef_o),
  .sys_rd_data_o    (sys_rd_data_o),
  .ext_rd_i         (ext_rd_i),
  .ext_rd_done_o    (ext_rd_done_o),
  .ext_rd_data_o    (ext_rd_data_o),
  .tbs_wr_i         (tbs_wr_i),
  .tbs_el_i         (tbs_el_i),
  .tbs_trap_el2_i   (tbs_trap_el2_i),
  .tbs_trap_el3_i   (tbs_trap_el3_i),
  .tbs_wr_done_o    (tbs_wr_done_o),
  .tbs_wr_result_o  (tbs_wr_result_o),
  .tbs_wr_trap_el_o (tbs_wr_trap_el_o),
  .tbs_wr_class_o   (tbs_wr_class_o)
);

// >>> tb/tasr_regs_bench.sv
module tasr_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, rd = 0, erd = 0, wr = 0, t2 = 0, t3 = 0;
  logic [1:0] sel = 0, el = 0, wel = 0, root, realm, sec, ns, res, tel;
  logic done, undef, edone, wdone, done_nt, undef_nt;
  logic [63:0] data, exp, data_nt;
  logic [31:0] edata;
  logic [5:0] cls;
  integer n_errors = 0, compares = 0;
  tasr_auth_src src (.sel_i(sel), .root_o(root), .realm_o(realm), .sec_o(sec), .ns_o(ns));
  tasr_regs uut (.core_clk_i(clk), .reset_n_i(rst_n), .main_root_ni_i(root),
    .main_realm_ni_i(realm), .secure_ni_i(sec), .nonsecure_ni_i(ns), .sys_rd_i(rd),
    .sys_el_i(el), .sys_rd_done_o(done), .sys_rd_undef_o(undef), .sys_rd_data_o(data),
    .ext_rd_i(erd), .ext_rd_done_o(edone), .ext_rd_data_o(edata), .tbs_wr_i(wr),
    .tbs_el_i(wel), .tbs_trap_el2_i(t2), .tbs_trap_el3_i(t3), .tbs_wr_done_o(wdone),
    .tbs_wr_result_o(res), .tbs_wr_trap_el_o(tel), .tbs_wr_class_o(cls));
  // A second copy built without the trace feature shares every input.
  tasr_regs #(.TRACE_PRESENT(0)) uut_nt (.core_clk_i(clk), .reset_n_i(rst_n),
    .main_root_ni_i(root), .main_realm_ni_i(realm), .secure_ni_i(sec), .nonsecure_ni_i(ns),
    .sys_rd_i(rd), .sys_el_i(el), .sys_rd_done_o(done_nt), .sys_rd_undef_o(undef_nt),
    .sys_rd_data_o(data_nt), .ext_rd_i(erd), .ext_rd_done_o(), .ext_rd_data_o(),
    .tbs_wr_i(wr), .tbs_el_i(wel), .tbs_trap_el2_i(t2), .tbs_trap_el3_i(t3),
    .tbs_wr_done_o(), .tbs_wr_result_o(), .tbs_wr_trap_el_o(), .tbs_wr_class_o());
  initial forever #12.5 clk = ~clk;
  task chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Both views are read in the same cycle so they see identical inputs.
  task t_read(input logic [1:0] e);
    logic [63:0] word;
    @(posedge clk);
    sel <= e; rd <= 1; erd <= 1; el <= e;
    @(posedge clk);
    rd <= 0; erd <= 0;
    @(negedge clk);
    word = {36'h0, root, 10'h0, realm, 6'h0, sec, 2'h0, ns, 2'h0};
    exp = (e == 0) ? 64'h0 : word;
    chk(done, 1);
    chk(undef, e == 0);
    chk(data, exp);
    chk(edone, 1);
    chk(edata, word[31:0]);
    chk(done_nt, 1);
    chk(undef_nt, 1);
    chk(data_nt, 0);
  endtask
  task t_write(input logic [1:0] e, input logic a, b, input logic [1:0] r, te);
    @(posedge clk);
    wr <= 1; wel <= e; t2 <= a; t3 <= b;
    @(posedge clk);
    wr <= 0;
    @(negedge clk);
    chk(wdone, 0);
    @(negedge clk);
    chk(wdone, 1);
    chk(res, r);
    chk(tel, te);
    chk(cls, r == 2 ? 6'h18 : 6'h0);
  endtask
  // A mid-run reset must clear every held answer at once, without a clock edge.
  task t_reset;
    @(posedge clk);
    rst_n <= 0;
    @(negedge clk);
    chk(data, 0);
    chk(edata, 0);
    chk(res, 0);
    chk(tel, 0);
    chk(cls, 0);
    @(posedge clk);
    rst_n <= 1;
  endtask
  task final_report;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) t_read(i[1:0]);
    t_write(0, 1, 1, 1, 0);
    t_write(1, 1, 1, 2, 2);
    t_write(1, 0, 1, 2, 3);
    t_write(1, 0, 0, 0, 0);
    t_write(2, 1, 1, 2, 3);
    t_reset;
    t_read(2'h2);
    t_write(2, 1, 0, 0, 0);
    t_write(3, 1, 1, 0, 0);
    final_report;
  end
endmodule // tasr_regs_bench
